// ---- design/osd_row_seq.v ----
// row sequencer, rank registers and pixel store addressing of the display
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`include "osd_map.vh"

// Contract
// - glyph store 8192 bytes, 6528 used, on-screen first
// - twelve-pixel line in two bytes, left first
// - on-screen: 18 blocks of 256 bytes
// - codes zero and one are spaces always
// - caption glyph 8x10, bottom lines underline only
// - caption: 10x128 basic, then 10x64 extended
// - caption box glyphs at codes two to seven
// - vsync flag at vsync starting edge
// - line match flag on target line
// - transfer enable copies outer to inner
// - disabled with pll: writes hit both ranks
// - sync and colour polarities selectable
// - status read shows flags, write clears
// - row mode and blink from matrix start
// - lines outside matrix range show border
// - target past picture never matches
// - character registers 1 to 34
// - reads past last glyph allowed
// - two bits invert sync inputs
// - top bit marks control or extended code
module osd_row_seq
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        hsync_pin,
  input  wire        vsync_pin,
  output wire        irq,
  output reg  [9:0]  line_count,
  output reg         row_cc_mode,
  output reg         row_blink,
  output reg         row_in_range,
  output reg  [5:0]  row_glyph_line,
  input  wire [5:0]  char_index,
  output reg  [7:0]  char_code,
  output reg         code_kind_bit,
  input  wire        fetch_req,
  input  wire [7:0]  fetch_code,
  input  wire [4:0]  fetch_line,
  input  wire        fetch_half,
  input  wire        fetch_cc,
  output reg  [12:0] fetch_addr,
  output reg         fetch_blank,
  output reg         fetch_box,
  output reg         fetch_underline_only,
  input  wire        fast_blank_raw,
  input  wire        red_raw,
  input  wire        green_raw,
  input  wire        blue_raw,
  input  wire        intensity_raw,
  output reg         fast_blank_out,
  output reg         red_out,
  output reg         green_out,
  output reg         blue_out,
  output reg         intensity_out
);

  // ==================================================
  // declarations
  reg  [4:0]  enctl_reg;
  reg  [6:0]  outctl_reg;
  reg         vsync_flag;
  reg         line_match_flag;
  reg  [9:0]  evline_reg;
  reg  [7:0]  mstart_reg;
  reg  [7:0]  mend_reg;
  reg  [9:0]  row_start_in;
  reg  [7:0]  mstart_in;
  reg  [7:0]  mend_in;
  reg  [7:0]  outer_rank [0:`OSD_NCHAR-1];
  reg  [7:0]  inner_rank [0:`OSD_NCHAR-1];
  reg  [1:0]  hs_sync;
  reg  [1:0]  vs_sync;
  reg         hs_last;
  reg         vs_last;
  reg  [9:0]  line_next;
  reg  [31:0] rd_next;
  reg  [12:0] addr_next;
  reg  [9:0]  row_ofs;
  reg  [5:0]  char_pos;
  wire        wr_acc;
  wire        rd_setup;
  wire        mapped;
  wire        is_char;
  wire [11:0] char_ofs;
  wire [5:0]  wr_index;
  wire        hs_lvl;
  wire        vs_lvl;
  wire        hs_edge;
  wire        vs_edge;
  wire        line_tick;
  wire        match;
  wire        rank_transfer_enable;
  wire        mirror;
  wire        stat_wr;

  // ==================================================
  // apb decode; no wait states, unmapped offsets answer with an error
  assign char_ofs = paddr - `OSD_CHAR_OFS;
  assign wr_index = char_ofs[7:2];
  assign is_char  = (paddr >= `OSD_CHAR_OFS) && (paddr <= `OSD_CHAR_LAST)
                    && (paddr[1:0] == 2'b00);
  assign mapped   = is_char || (paddr == `OSD_ENCTL_OFS)
                    || (paddr == `OSD_STAT_OFS)
                    || (paddr == `OSD_OUTCTL_OFS)
                    || (paddr == `OSD_EVLINE_OFS)
                    || (paddr == `OSD_MSTART_OFS)
                    || (paddr == `OSD_MEND_OFS)
                    || (paddr == `OSD_LINECNT_OFS);
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;
  assign wr_acc   = ce && psel && penable && pwrite && mapped;
  assign rd_setup = ce && psel && !penable && !pwrite;
  assign stat_wr  = wr_acc && (paddr == `OSD_STAT_OFS);

  // ==================================================
  // sync inputs: two flops, then polarity, then start-edge detect
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hs_sync <= 2'b00;
      vs_sync <= 2'b00;
      hs_last <= 1'b0;
      vs_last <= 1'b0;
    end
    else if (ce)
    begin
      hs_sync <= {hs_sync[0], hsync_pin};
      vs_sync <= {vs_sync[0], vsync_pin};
      hs_last <= hs_lvl;
      vs_last <= vs_lvl;
    end
  end

  // the level after the optional inversion is the active level
  assign hs_lvl    = hs_sync[1] ^ outctl_reg[`OSD_OC_HSYNC_POLARITY_INVERT];
  assign vs_lvl    = vs_sync[1] ^ outctl_reg[`OSD_OC_VSYNC_POLARITY_INVERT];
  assign hs_edge   = hs_lvl && !hs_last;
  assign vs_edge   = vs_lvl && !vs_last;
  assign line_tick = hs_edge || vs_edge;

  // ==================================================
  // scan line counter, restarts at each vertical sync start
  always @*
  begin
    line_next = line_count;
    if (vs_edge)
      line_next = 10'h000;
    else if (hs_edge && (line_count != 10'h3ff))
      line_next = line_count + 10'h001;
  end

  // the counter restarts at each vertical sync and stops at 3ff, so a target
  // beyond the last picture line is simply never reached
  assign match  = line_tick && (line_next == evline_reg);
  assign rank_transfer_enable   = match && enctl_reg[`OSD_EN_RANK_TRANSFER_ENABLE];
  assign mirror = !enctl_reg[`OSD_EN_DISP] && enctl_reg[`OSD_EN_PLL];

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      line_count <= 10'h000;
    else if (ce)
      line_count <= line_next;
  end

  // ==================================================
  // control registers; flag set beats a clearing write
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enctl_reg       <= `OSD_ENCTL_RST;
      outctl_reg      <= `OSD_OUTCTL_RST;
      evline_reg      <= 10'h3ff;
      mstart_reg      <= 8'h00;
      mend_reg        <= 8'h00;
      vsync_flag      <= 1'b0;
      line_match_flag <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_acc && (paddr == `OSD_ENCTL_OFS))
        enctl_reg <= pwdata[4:0];
      if (wr_acc && (paddr == `OSD_OUTCTL_OFS))
        outctl_reg <= pwdata[6:0];
      if (wr_acc && (paddr == `OSD_EVLINE_OFS))
        evline_reg <= pwdata[9:0];
      if (wr_acc && (paddr == `OSD_MSTART_OFS))
        mstart_reg <= pwdata[7:0];
      if (wr_acc && (paddr == `OSD_MEND_OFS))
        mend_reg <= pwdata[7:0];
      if (vs_edge && enctl_reg[`OSD_EN_VSIRQ])
        vsync_flag <= 1'b1;
      else if (stat_wr)
        vsync_flag <= 1'b0;
      if (match && enctl_reg[`OSD_EN_LMIRQ])
        line_match_flag <= 1'b1;
      else if (stat_wr)
        line_match_flag <= 1'b0;
    end
  end

  // request stays up until software writes the status register or clears the flag's enable bit
  assign irq = (vsync_flag && enctl_reg[`OSD_EN_VSIRQ])
               || (line_match_flag && enctl_reg[`OSD_EN_LMIRQ]);

  // ==================================================
  // row parameters of the inner rank
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      row_start_in <= 10'h3ff;
      mstart_in    <= 8'h00;
      mend_in      <= 8'h00;
    end
    else if (ce)
    begin
      if (rank_transfer_enable)
      begin
        row_start_in <= evline_reg;
        mstart_in    <= mstart_reg;
        mend_in      <= mend_reg;
      end
      else if (wr_acc && mirror)
      begin
        if (paddr == `OSD_EVLINE_OFS)
          row_start_in <= pwdata[9:0];
        if (paddr == `OSD_MSTART_OFS)
          mstart_in <= pwdata[7:0];
        if (paddr == `OSD_MEND_OFS)
          mend_in <= pwdata[7:0];
      end
    end
  end

  // ==================================================
  // character ranks, one entry per generate pass; the transfer copies
  // all entries on the same edge so a row never mixes old and new codes
  genvar gi;
  generate
    for (gi = 0; gi < `OSD_NCHAR; gi = gi + 1)
    begin : g_char
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          outer_rank[gi] <= 8'h00;
          inner_rank[gi] <= 8'h00;
        end
        else if (ce)
        begin
          if (wr_acc && is_char && (wr_index == gi))
            outer_rank[gi] <= pwdata[7:0];
          if (rank_transfer_enable)
            inner_rank[gi] <= outer_rank[gi];
          else if (wr_acc && mirror && is_char && (wr_index == gi))
            inner_rank[gi] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // ==================================================
  // read data, latched in the setup cycle for the access cycle
  always @*
  begin
    rd_next = 32'h0000_0000;
    if (is_char)
      rd_next[7:0] = outer_rank[wr_index];
    else
      case (paddr)
        `OSD_ENCTL_OFS:   rd_next[4:0] = enctl_reg;
        `OSD_STAT_OFS:    rd_next[1:0] = {line_match_flag, vsync_flag};
        `OSD_OUTCTL_OFS:  rd_next[6:0] = outctl_reg;
        `OSD_EVLINE_OFS:  rd_next[9:0] = evline_reg;
        `OSD_MSTART_OFS:  rd_next[7:0] = mstart_reg;
        `OSD_MEND_OFS:    rd_next[7:0] = mend_reg;
        `OSD_LINECNT_OFS: rd_next[9:0] = line_count;
        default:          rd_next = 32'h0000_0000;
      endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
      prdata <= rd_next;
  end

  // ==================================================
  // row state for the renderer
  always @*
  begin
    row_ofs = line_count - row_start_in;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      row_cc_mode    <= 1'b0;
      row_blink      <= 1'b0;
      row_in_range   <= 1'b0;
      row_glyph_line <= 6'h00;
    end
    else if (ce)
    begin
      row_cc_mode    <= mstart_in[`OSD_MS_MODE];
      row_blink      <= mstart_in[`OSD_MS_BLINK];
      row_glyph_line <= row_ofs[5:0];
      // matrix bounds sit in the low six bits; outside them is border
      row_in_range   <= (line_count >= row_start_in)
                        && (row_ofs[9:6] == 4'h0)
                        && (row_ofs[5:0] >= mstart_in[5:0])
                        && (row_ofs[5:0] <= mend_in[5:0]);
    end
  end

  // ==================================================
  // character read port; index 1..34, reads past the end are legal
  always @*
  begin
    char_pos = char_index - 6'h01;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      char_code     <= 8'h00;
      code_kind_bit <= 1'b0;
    end
    else if (ce)
    begin
      if ((char_index != 6'h00) && (char_index <= 6'd34))
      begin
        char_code     <= inner_rank[char_pos];
        code_kind_bit <= inner_rank[char_pos][7];
      end
      else
      begin
        char_code     <= 8'h00;
        code_kind_bit <= 1'b0;
      end
    end
  end

  // ==================================================
  // glyph store addressing inside the 8 KiB window (13-bit offset)
  always @*
  begin
    addr_next = 13'h0000;
    if (!fetch_cc)
      addr_next = {fetch_line, fetch_code[6:0], fetch_half};
    else if (fetch_code[7])
      addr_next = `OSD_CC_EXT_BASE + {2'b00, fetch_line, 6'h00}
                  + {7'h00, fetch_code[5:0]};
    else
      addr_next = `OSD_CC_BASE + {1'b0, fetch_line, 7'h00}
                  + {6'h00, fetch_code[6:0]};
  end

  // the half bit picks the left eight or the right four pixels
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fetch_addr           <= 13'h0000;
      fetch_blank          <= 1'b1;
      fetch_box            <= 1'b0;
      fetch_underline_only <= 1'b0;
    end
    else if (ce && fetch_req)
    begin
      fetch_addr <= addr_next;
      // spaces blank whatever is stored; so do lines past the store
      fetch_blank <= (!fetch_code[7] && (fetch_code[6:1] == 6'h00))
                     || (fetch_cc && (fetch_line >= `OSD_CC_LINES))
                     || (!fetch_cc
                         && (fetch_line >= `OSD_OSD_LINES));
      fetch_underline_only <= fetch_cc
                              && (fetch_line >= `OSD_CC_LINES);
      fetch_box <= fetch_cc && !fetch_code[7]
                   && (fetch_code[6:0] >= `OSD_BOX_FIRST)
                   && (fetch_code[6:0] <= `OSD_BOX_LAST);
    end
  end

  // ==================================================
  // output polarity, registered so the pins never glitch
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fast_blank_out <= 1'b0;
      red_out        <= 1'b0;
      green_out      <= 1'b0;
      blue_out       <= 1'b0;
      intensity_out  <= 1'b0;
    end
    else if (ce)
    begin
      fast_blank_out <= fast_blank_raw ^ outctl_reg[`OSD_OC_FBINV];
      red_out        <= red_raw ^ outctl_reg[`OSD_OC_RINV];
      green_out      <= green_raw ^ outctl_reg[`OSD_OC_GINV];
      blue_out       <= blue_raw ^ outctl_reg[`OSD_OC_BINV];
      intensity_out  <= intensity_raw ^ outctl_reg[`OSD_OC_IINV];
    end
  end

endmodule

// ---- design/osd_map.vh ----
// register offsets, field positions and reset values of the row sequencer
`ifndef OSD_MAP_VH
`define OSD_MAP_VH

// ==================================================
// register byte offsets
`define OSD_ENCTL_OFS    12'h000
`define OSD_STAT_OFS     12'h004
`define OSD_OUTCTL_OFS   12'h008
`define OSD_EVLINE_OFS   12'h00c
`define OSD_MSTART_OFS   12'h010
`define OSD_MEND_OFS     12'h014
`define OSD_LINECNT_OFS  12'h018
`define OSD_CHAR_OFS     12'h080
`define OSD_CHAR_LAST    12'h104
`define OSD_NCHAR        34

// ==================================================
// enable control fields
`define OSD_EN_VSIRQ     0
`define OSD_EN_LMIRQ     1
`define OSD_EN_RANK_TRANSFER_ENABLE      2
`define OSD_EN_DISP      3
`define OSD_EN_PLL       4
`define OSD_ENCTL_RST    5'h00

// ==================================================
// status and output control fields
`define OSD_ST_VSYNC     0
`define OSD_ST_LMATCH    1
`define OSD_OC_HSYNC_POLARITY_INVERT      0
`define OSD_OC_VSYNC_POLARITY_INVERT      1
`define OSD_OC_FBINV     2
`define OSD_OC_RINV      3
`define OSD_OC_GINV      4
`define OSD_OC_BINV      5
`define OSD_OC_IINV      6
`define OSD_OUTCTL_RST   7'h00

// ==================================================
// matrix start fields and pixel store layout
`define OSD_MS_MODE      7
`define OSD_MS_BLINK     6
`define OSD_CC_BASE      13'h1200
`define OSD_CC_EXT_BASE  13'h1700
`define OSD_CC_LINES     5'h0a
`define OSD_OSD_LINES    5'h12
`define OSD_BOX_FIRST    7'h02
`define OSD_BOX_LAST     7'h07

`endif

// ---- test/osd_row_seq_sva.sv ----
// concurrent checks on the row sequencer ports
`timescale 1ns/1ns

// ========================================
// checker on fetch, character and irq ports
module osd_row_seq_sva
(
  input logic        pclk,
  input logic        presetn,
  input logic        ce,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic        irq,
  input logic [5:0]  char_index,
  input logic [7:0]  char_code,
  input logic        code_kind_bit,
  input logic        fetch_req,
  input logic [7:0]  fetch_code,
  input logic [4:0]  fetch_line,
  input logic        fetch_half,
  input logic        fetch_cc,
  input logic [12:0] fetch_addr,
  input logic        fetch_blank,
  input logic        fetch_box,
  input logic        fetch_underline_only
);
  logic       take;
  logic [7:0] q_code;
  logic [4:0] q_line;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign take = ce && fetch_req;
  // request copies, so address checks see what was asked
  always @(posedge pclk)
  begin
    q_code <= fetch_code;
    q_line <= fetch_line;
  end
  blank_space_a:
  assert property (take && fetch_code[7:1] == 7'h00 |=> fetch_blank)
  else $error("space glyph fetch not blank");
  osd_addr_a:
  assert property (take && !fetch_cc && fetch_line < 5'd18 |=>
    fetch_addr == {q_line, q_code[6:0], $past(fetch_half)})
  else $error("glyph address wrong");
  cc_basic_a:
  assert property (take && fetch_cc && !fetch_code[7] && fetch_line < 5'd10
    |=> fetch_addr == 13'h1200 + {1'b0, q_line, 7'h00} + q_code[6:0])
  else $error("caption address wrong");
  cc_ext_a:
  assert property (take && fetch_cc && fetch_code[7] && fetch_line < 5'd10
    |=> fetch_addr == 13'h1700 + {2'h0, q_line, 6'h00} + q_code[5:0])
  else $error("extended caption address wrong");
  box_glyph_a:
  assert property (take && fetch_cc |=>
    fetch_box == (q_code inside {[8'h02:8'h07]}))
  else $error("box glyph flag wrong");
  underline_a:
  assert property (take && fetch_cc && fetch_line >= 5'd10 |=>
    fetch_underline_only && fetch_blank)
  else $error("caption bottom line not underline only");
  store_size_a:
  assert property (!fetch_blank |-> fetch_addr < 13'h1980)
  else $error("fetch beyond used store");
  char_range_a:
  assert property (ce && (char_index == 6'd0 || char_index > 6'd34)
    |=> char_code == 8'h00)
  else $error("code outside register range");
  kind_bit_a:
  assert property (code_kind_bit == char_code[7])
  else $error("kind bit differs from code");
  irq_clear_a:
  assert property (ce && psel && penable && pwrite && paddr == 12'h004
    |=> !irq)
  else $error("irq stays after status write");
  cover property (take && fetch_cc && fetch_code[7]);
  cover property ($rose(irq));
  cover property (take && fetch_cc && fetch_line >= 5'd10);
endmodule

bind osd_row_seq osd_row_seq_sva osd_row_seq_sva_i
(
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .irq(irq),
  .char_index(char_index), .char_code(char_code),
  .code_kind_bit(code_kind_bit), .fetch_req(fetch_req),
  .fetch_code(fetch_code), .fetch_line(fetch_line),
  .fetch_half(fetch_half), .fetch_cc(fetch_cc),
  .fetch_addr(fetch_addr), .fetch_blank(fetch_blank),
  .fetch_box(fetch_box), .fetch_underline_only(fetch_underline_only)
);

// ---- test/osd_sync_src.sv ----
// television chassis model making the sync pins
`timescale 1ns/1ns

// ========================================
// sync source, idle low while run is low
module osd_sync_src
#(
  parameter LINE_CYC = 24,
  parameter NLINES   = 12
)
(
  input  wire pclk,
  input  wire presetn,
  input  wire run,
  output reg  hsync_pin,
  output reg  vsync_pin
);
  integer h;
  integer v;
  // vsync starts mid-line so its start never shares an edge with hsync
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn || !run)
    begin
      h <= 0;
      v <= 0;
      hsync_pin <= 1'b0;
      vsync_pin <= 1'b0;
    end
    else
    begin
      hsync_pin <= (h < 3);
      vsync_pin <= (v == 0) && (h >= 8);
      h <= (h == LINE_CYC - 1) ? 0 : h + 1;
      if (h == LINE_CYC - 1)
        v <= (v == NLINES - 1) ? 0 : v + 1;
    end
  end
endmodule

// ---- test/osd_row_seq_test.sv ----
// self-checking bench of the row sequencer
`timescale 1ns/1ns
`include "osd_map.vh"

// ========================================
// bench top
module osd_row_seq_test;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        hsync_pin, vsync_pin, irq, run, err;
  logic        row_cc_mode, row_blink, code_kind_bit, row_in_range;
  logic [9:0]  line_count;
  logic [5:0]  glyph_line;
  logic [5:0]  char_index;
  logic [7:0]  char_code, fetch_code;
  logic        fetch_req, fetch_half, fetch_cc;
  logic [4:0]  fetch_line, raw;
  wire  [4:0]  col;
  logic [12:0] fetch_addr;
  logic        fetch_blank, fetch_box, fetch_uline;
  integer      bad_count, n_tests;

  osd_row_seq osd_row_seq_i
  (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hsync_pin(hsync_pin), .vsync_pin(vsync_pin), .irq(irq),
    .line_count(line_count), .row_cc_mode(row_cc_mode),
    .row_blink(row_blink), .row_in_range(row_in_range),
    .row_glyph_line(glyph_line), .char_index(char_index),
    .char_code(char_code), .code_kind_bit(code_kind_bit),
    .fetch_req(fetch_req), .fetch_code(fetch_code),
    .fetch_line(fetch_line), .fetch_half(fetch_half),
    .fetch_cc(fetch_cc), .fetch_addr(fetch_addr),
    .fetch_blank(fetch_blank), .fetch_box(fetch_box),
    .fetch_underline_only(fetch_uline), .fast_blank_raw(raw[4]),
    .red_raw(raw[3]), .green_raw(raw[2]), .blue_raw(raw[1]),
    .intensity_raw(raw[0]), .fast_blank_out(col[4]), .red_out(col[3]),
    .green_out(col[2]), .blue_out(col[1]), .intensity_out(col[0])
  );
  osd_sync_src osd_sync_src_i
  (
    .pclk(pclk), .presetn(presetn), .run(run),
    .hsync_pin(hsync_pin), .vsync_pin(vsync_pin)
  );

  // ========================================
  // compare, bus and fetch tasks
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t flag %b want %b", $time, got, exp);
    end
  endtask
  // request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk_reg(rd, e);
  endtask
  task automatic wait_irq();
    integer k;
    k = 0;
    while (irq !== 1'b1 && k < 800)
    begin
      @(posedge pclk);
      k++;
    end
    chk_bit(irq, 1'b1);
    run <= 1'b0;
  endtask
  // ea of 1fff skips the address; ef is blank, box, underline
  task automatic fchk(input logic cc, input logic [7:0] c,
    input logic [4:0] l, input logic h, input logic [12:0] ea,
    input logic [2:0] ef);
    @(posedge pclk);
    fetch_req <= 1'b1;
    fetch_cc <= cc;
    fetch_code <= c;
    fetch_line <= l;
    fetch_half <= h;
    @(posedge pclk);
    fetch_req <= 1'b0;
    @(negedge pclk);
    if (ea != 13'h1fff)
      chk_reg({19'h0, fetch_addr}, {19'h0, ea});
    chk_reg({29'h0, fetch_blank, fetch_box, fetch_uline}, {29'h0, ef});
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ========================================
  // clock, watchdog and test sequence
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // the tests need about 1200 cycles
  initial
  begin
    repeat (25000) @(posedge pclk);
    bad_count++;
    print_verdict();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, run, fetch_req, fetch_half} = 0;
    {paddr, pwdata, char_index, fetch_code, fetch_line, fetch_cc} = 0;
    ce = 1'b1;
    raw = 5'h1f;
    bad_count = 0;
    n_tests = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`OSD_STAT_OFS, 32'h0);
    rd_chk(`OSD_EVLINE_OFS, 32'h3ff);
    rd_chk(12'h108, 32'h0);
    chk_bit(err, 1'b1);
    // reset already clears the characters; write zero to them all again
    for (int i = 0; i < `OSD_NCHAR; i++)
      apb(1'b1, `OSD_CHAR_OFS + 12'(4 * i), 32'h0);
    apb(1'b1, `OSD_ENCTL_OFS, 32'h11);
    run <= 1'b1;
    wait_irq();
    rd_chk(`OSD_STAT_OFS, 32'h1);
    apb(1'b1, `OSD_STAT_OFS, 32'h0);
    @(negedge pclk);
    chk_bit(irq, 1'b0);
    rd_chk(`OSD_STAT_OFS, 32'h0);
    // unit on and pll off: outer writes stay outside
    apb(1'b1, `OSD_ENCTL_OFS, 32'h0e);
    apb(1'b1, `OSD_EVLINE_OFS, 32'h5);
    apb(1'b1, `OSD_MSTART_OFS, 32'hc0);
    apb(1'b1, `OSD_CHAR_OFS, 32'h41);
    char_index <= 6'd1;
    repeat (2) @(negedge pclk);
    chk_reg({24'h0, char_code}, 32'h0);
    @(posedge pclk);
    run <= 1'b1;
    wait_irq();
    rd_chk(`OSD_STAT_OFS, 32'h2);
    chk_reg({24'h0, char_code}, 32'h41);
    chk_bit(row_cc_mode, 1'b1);
    chk_bit(row_blink, 1'b1);
    // the row starts on the target line with a one-line matrix range
    chk_reg({22'h0, line_count}, 32'h5);
    chk_bit(row_in_range, 1'b1);
    chk_reg({26'h0, glyph_line}, 32'h0);
    apb(1'b1, `OSD_STAT_OFS, 32'h0);
    apb(1'b1, `OSD_ENCTL_OFS, 32'h0a);
    apb(1'b1, `OSD_CHAR_OFS, 32'h22);
    run <= 1'b1;
    wait_irq();
    rd_chk(`OSD_STAT_OFS, 32'h2);
    chk_reg({24'h0, char_code}, 32'h41);
    apb(1'b1, `OSD_STAT_OFS, 32'h0);
    apb(1'b1, `OSD_ENCTL_OFS, 32'h10);
    apb(1'b1, `OSD_CHAR_OFS + 12'h4, 32'h85);
    char_index <= 6'd2;
    repeat (2) @(negedge pclk);
    chk_reg({24'h0, char_code}, 32'h85);
    chk_bit(code_kind_bit, 1'b1);
    @(posedge pclk);
    char_index <= 6'd35;
    repeat (2) @(negedge pclk);
    chk_reg({24'h0, char_code}, 32'h0);
    apb(1'b1, `OSD_EVLINE_OFS, 32'd100);
    apb(1'b1, `OSD_ENCTL_OFS, 32'h12);
    run <= 1'b1;
    repeat (700) @(posedge pclk);
    run <= 1'b0;
    rd_chk(`OSD_STAT_OFS, 32'h0);
    chk_reg({27'h0, col}, 32'h1f);
    apb(1'b1, `OSD_OUTCTL_OFS, 32'h7c);
    repeat (2) @(negedge pclk);
    chk_reg({27'h0, col}, 32'h0);
    rd_chk(`OSD_OUTCTL_OFS, 32'h7c);
    // inverted sync polarity: the idle low pins now count as active
    apb(1'b1, `OSD_ENCTL_OFS, 32'h11);
    apb(1'b1, `OSD_OUTCTL_OFS, 32'h03);
    rd_chk(`OSD_STAT_OFS, 32'h1);
    rd_chk(`OSD_LINECNT_OFS, 32'h0);
    fchk(1'b0, 8'h05, 5'd3, 1'b1, 13'h030b, 3'b000);
    fchk(1'b0, 8'h01, 5'd0, 1'b0, 13'h0002, 3'b100);
    fchk(1'b0, 8'h00, 5'd17, 1'b0, 13'h1100, 3'b100);
    fchk(1'b0, 8'h05, 5'd18, 1'b0, 13'h1fff, 3'b100);
    fchk(1'b1, 8'h10, 5'd9, 1'b0, 13'h1690, 3'b000);
    fchk(1'b1, 8'ha0, 5'd2, 1'b0, 13'h17a0, 3'b000);
    fchk(1'b1, 8'hbf, 5'd9, 1'b0, 13'h197f, 3'b000);
    fchk(1'b1, 8'h07, 5'd4, 1'b0, 13'h1407, 3'b010);
    fchk(1'b1, 8'h02, 5'd0, 1'b0, 13'h1202, 3'b010);
    fchk(1'b1, 8'h08, 5'd0, 1'b0, 13'h1208, 3'b000);
    fchk(1'b1, 8'h41, 5'd10, 1'b0, 13'h1fff, 3'b101);
    print_verdict();
  end
endmodule
